// ### cfstm_pkg.sv
// Package of constants and types for the CAN FIFO status, timer and mask block.
//------------------------------------------------------------------------------
// Summary of operation
// - Read-only per-FIFO interrupt pending vector, 32 bits.
// - Read-only per-FIFO receive overflow vector, 32 bits.
// - Timestamp counter runs while capture enable set.
// - Prescale zero ticks every clock; N ticks every N.
// - Capture enable clear freezes counter and prescaler.
// - Timer register write clears internal prescaler count.
// - Count in upper half, prescale in lower.
// - Bits 31-21 mask standard identifier bits.
// - Bits 17-0 mask extended identifier bits.
// - Bit 19 set: frame format must match filter.
// - Bit 19 clear: either format accepted on match.
// - Mask writes accepted only in configuration mode.
// - Three acceptance masks, same layout, reset zero.
// - Two-bit selector picks mask zero to three.
// - Interrupt code names lowest pending FIFO number.
//------------------------------------------------------------------------------
package cfstm_pkg;

    //--------------------------------------------------------------------------
    // Register byte offsets on the APB.
    //--------------------------------------------------------------------------
    localparam logic [7:0] OFS_FIFO_PEND = 8'h00;
    localparam logic [7:0] OFS_RX_OVF = 8'h04;
    localparam logic [7:0] OFS_TS_TIMER = 8'h08;
    localparam logic [7:0] OFS_MASK0 = 8'h0C;
    localparam logic [7:0] OFS_MASK1 = 8'h10;
    localparam logic [7:0] OFS_MASK2 = 8'h14;
    localparam logic [7:0] OFS_CONTROL = 8'h18;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
    localparam logic [7:0] OFS_INT_CODE = 8'h24;

    //--------------------------------------------------------------------------
    // Field positions and encodings.
    //--------------------------------------------------------------------------
    localparam int CAPTURE_BIT = 20;
    localparam int MODE_LSB = 21;
    localparam logic [2:0] MODE_CONFIG = 3'h4;
    localparam int MASK_SID_LSB = 21;
    localparam int MASK_TYPE_BIT = 19;
    localparam logic [31:0] MASK_WRITABLE = 32'hFFEB_FFFF;
    localparam logic [31:0] CONTROL_WRITABLE = 32'h00F0_0000;
    localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
    localparam logic [6:0] INT_CODE_NONE = 7'h40;
    localparam int IRQ_BITS = 3;
    localparam int IRQ_TMR_OVF = 0;
    localparam int IRQ_FIFO = 1;
    localparam int IRQ_RX_OVF = 2;

    // Time-stamp register fields.
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] prescale;
    } cfstm_timer_s;

    // Acceptance mask fields.
    typedef struct packed {
        logic [10:0] sid;
        logic unused20;
        logic type_match;
        logic unused18;
        logic [17:0] eid;
    } cfstm_mask_s;

    // Identifier of a received message or a filter.
    typedef struct packed {
        logic [10:0] sid;
        logic [17:0] eid;
        logic extended;
    } cfstm_id_s;

endpackage

// ### cfstm_top.sv
// CAN FIFO status, timestamp timer and acceptance mask block with APB slave.
module cfstm_top
    import cfstm_pkg::*;
#(
    parameter int NUM_FILTERS = 4
) (
    // Clock and reset.
    input wire logic REF_CLK,
    input wire logic SRST,
    // APB slave.
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Per-FIFO conditions from the FIFO logic.
    input wire logic [31:0] FIFO_COND,
    input wire logic [31:0] FIFO_COND_EN,
    input wire logic [31:0] FIFO_OVF_SET,
    input wire logic [31:0] FIFO_OVF_CLR,
    // Filter comparison inputs.
    input wire cfstm_id_s MSG_ID,
    input wire cfstm_id_s [NUM_FILTERS-1:0] FILTER_ID,
    input wire logic [NUM_FILTERS-1:0][1:0] MASK_SELECTOR,
    input wire logic [31:0] MASK3_VALUE,
    // Results.
    output logic [NUM_FILTERS-1:0] FILTER_MATCH,
    output logic [15:0] TIMESTAMP_COUNT,
    output logic TIMER_OVERFLOW,
    output logic [6:0] INTERRUPT_CODE,
    output logic IRQ
);

    //--------------------------------------------------------------------------
    // Storage.
    //--------------------------------------------------------------------------
    cfstm_timer_s timer_r; // Count and prescale setting.
    logic [15:0] pre_cnt_r; // Internal prescaler count.
    logic [31:0] mask_r [3]; // Acceptance masks zero to two.
    logic [31:0] control_r; // Capture enable and operating mode.
    logic [31:0] ovf_r; // Sticky receive overflow flags.
    logic ovf_pulse_r; // Counter rolled over this cycle.
    logic [IRQ_BITS-1:0] irq_stat_r; // Sticky event flags.
    logic [IRQ_BITS-1:0] irq_mask_r; // Event enables.
    logic [31:0] prdata_r; // Registered read data.
    logic [31:0] fifo_pend; // Live pending vector.
    logic [31:0] fifo_pend_d_r; // Previous pending, for edge events.
    logic [31:0] ovf_d_r; // Previous overflow, for edge events.
    logic [IRQ_BITS-1:0] events; // One-cycle event strobes.
    logic wr_en; // Write in access phase.
    logic rd_en; // Read in access phase.
    logic capture_en; // Timer runs when set.
    logic config_mode; // Operating mode is configuration.
    logic tick; // Counter advances this cycle.

    assign wr_en = PSEL & PENABLE & PWRITE;
    assign rd_en = PSEL & PENABLE & ~PWRITE;
    assign capture_en = control_r[CAPTURE_BIT];
    assign config_mode = control_r[MODE_LSB +: 3] == MODE_CONFIG;

    // The slave always answers in the first access cycle; no wait states.
    assign PREADY = 1'b1;
    assign PSLVERR = 1'b0;
    assign PRDATA = prdata_r;

    //--------------------------------------------------------------------------
    // FIFO status vectors.
    //--------------------------------------------------------------------------
    // Pending follows its enabled conditions with no storage of its own.
    assign fifo_pend = FIFO_COND & FIFO_COND_EN;

    // Overflow flags are set by the FIFO logic; a set wins over a clear.
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            ovf_r <= RESET_ZERO;
        end else begin
            ovf_r <= (ovf_r & ~FIFO_OVF_CLR) | FIFO_OVF_SET;
        end
    end

    //--------------------------------------------------------------------------
    // Timestamp timer.
    //--------------------------------------------------------------------------
    // A tick comes when the prescaler count has reached one less than the setting, so a
    // setting of zero ticks every clock and N ticks every N clocks.
    assign tick = capture_en & (pre_cnt_r + 16'h0001 >= timer_r.prescale
                                || timer_r.prescale == 16'h0000);

    // Prescaler count: cleared by a timer write, frozen without capture.
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            pre_cnt_r <= 16'h0000;
        end else if (wr_en && PADDR == OFS_TS_TIMER) begin
            pre_cnt_r <= 16'h0000;
        end else if (!capture_en) begin
            pre_cnt_r <= pre_cnt_r;
        end else if (tick) begin
            pre_cnt_r <= 16'h0000;
        end else begin
            pre_cnt_r <= pre_cnt_r + 16'h0001;
        end
    end

    // Count and prescale setting; software write takes priority over a tick.
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            timer_r <= RESET_ZERO;
        end else if (wr_en && PADDR == OFS_TS_TIMER) begin
            timer_r <= PWDATA;
        end else if (tick) begin
            timer_r.count <= timer_r.count + 16'h0001;
        end
    end

    // Rollover from all ones to zero is a one-cycle overflow strobe.
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            ovf_pulse_r <= 1'b0;
        end else begin
            ovf_pulse_r <= tick & (timer_r.count == 16'hFFFF)
                           & ~(wr_en && PADDR == OFS_TS_TIMER);
        end
    end

    assign TIMESTAMP_COUNT = timer_r.count;
    assign TIMER_OVERFLOW = ovf_pulse_r;

    //--------------------------------------------------------------------------
    // Control and acceptance masks.
    //--------------------------------------------------------------------------
    // Control holds capture enable and operating mode for this block.
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            control_r <= RESET_ZERO;
        end else if (wr_en && PADDR == OFS_CONTROL) begin
            control_r <= PWDATA & CONTROL_WRITABLE;
        end
    end

    // Masks only change in configuration mode, guarding live filtering.
    generate
        for (genvar m = 0; m < 3; m++) begin : g_mask
            always_ff @(posedge REF_CLK) begin
                if (SRST) begin
                    mask_r[m] <= RESET_ZERO;
                end else if (wr_en && config_mode
                             && PADDR == OFS_MASK0 + 8'(4 * m)) begin
                    mask_r[m] <= PWDATA & MASK_WRITABLE;
                end
            end
        end
    endgenerate

    //--------------------------------------------------------------------------
    // Filter comparison.
    //--------------------------------------------------------------------------
    generate
        for (genvar f = 0; f < NUM_FILTERS; f++) begin : g_filt
            cfstm_mask_s sel;
            logic id_eq;
            logic std_eq;
            // Two-bit selector; mask three comes from outside this block.
            always_comb begin
                case (MASK_SELECTOR[f])
                    2'h0: sel = mask_r[0];
                    2'h1: sel = mask_r[1];
                    2'h2: sel = mask_r[2];
                    default: sel = MASK3_VALUE;
                endcase
            end
            assign std_eq = ((MSG_ID.sid ^ FILTER_ID[f].sid) & sel.sid)
                            == 11'h000;
            assign id_eq = std_eq && (((MSG_ID.eid ^ FILTER_ID[f].eid)
                           & sel.eid) == 18'h00000
                           || !MSG_ID.extended);
            // Type check gates the match only when the mask asks for it.
            assign FILTER_MATCH[f] = id_eq && (!sel.type_match
                || MSG_ID.extended == FILTER_ID[f].extended);
        end
    endgenerate

    //--------------------------------------------------------------------------
    // Interrupt code and interrupt block.
    //--------------------------------------------------------------------------
    // Lowest pending FIFO wins; no pending FIFO reports the idle code.
    always_comb begin
        INTERRUPT_CODE = INT_CODE_NONE;
        for (int i = 31; i >= 0; i--) begin
            if (fifo_pend[i]) begin
                INTERRUPT_CODE = 7'(i);
            end
        end
    end

    // Edge detect status vectors into event strobes.
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            fifo_pend_d_r <= RESET_ZERO;
            ovf_d_r <= RESET_ZERO;
        end else begin
            fifo_pend_d_r <= fifo_pend;
            ovf_d_r <= ovf_r;
        end
    end

    assign events[IRQ_TMR_OVF] = ovf_pulse_r;
    assign events[IRQ_FIFO] = |(fifo_pend & ~fifo_pend_d_r);
    assign events[IRQ_RX_OVF] = |(ovf_r & ~ovf_d_r);

    // Sticky status cleared by reading it; a new event wins over the clear.
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            irq_stat_r <= '0;
        end else if (rd_en && PADDR == OFS_IRQ_STAT) begin
            irq_stat_r <= events;
        end else begin
            irq_stat_r <= irq_stat_r | events;
        end
    end

    // Mask register, same layout as the status.
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            irq_mask_r <= '0;
        end else if (wr_en && PADDR == OFS_IRQ_MASK) begin
            irq_mask_r <= PWDATA[IRQ_BITS-1:0];
        end
    end

    assign IRQ = |(irq_stat_r & irq_mask_r);

    //--------------------------------------------------------------------------
    // APB read data, registered at the edge that ends the setup phase.
    //--------------------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            prdata_r <= RESET_ZERO;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            // Sampled in setup so data is valid during the access phase.
            case (PADDR)
                OFS_FIFO_PEND: prdata_r <= fifo_pend;
                OFS_RX_OVF: prdata_r <= ovf_r;
                OFS_TS_TIMER: prdata_r <= timer_r;
                OFS_MASK0: prdata_r <= mask_r[0];
                OFS_MASK1: prdata_r <= mask_r[1];
                OFS_MASK2: prdata_r <= mask_r[2];
                OFS_CONTROL: prdata_r <= control_r;
                OFS_IRQ_STAT: prdata_r <= 32'(irq_stat_r);
                OFS_IRQ_MASK: prdata_r <= 32'(irq_mask_r);
                OFS_INT_CODE: prdata_r <= 32'(INTERRUPT_CODE);
                default: prdata_r <= RESET_ZERO;
            endcase
        end
    end

endmodule

// ### cfstm_asserts.sv
// Port-level assertions for the CAN FIFO status, timer and mask block.
module cfstm_asserts
    import cfstm_pkg::*;
(
    // Clock, reset and APB.
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    // FIFO status and timer.
    input wire logic [31:0] FIFO_COND,
    input wire logic [31:0] FIFO_COND_EN,
    input wire logic [15:0] TIMESTAMP_COUNT,
    input wire logic TIMER_OVERFLOW,
    input wire logic [6:0] INTERRUPT_CODE
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    logic cap_r; // Shadow of the capture enable.
    logic [15:0] pre_r; // Shadow of the prescale setting.
    logic [31:0] pend; // Enabled conditions per FIFO.
    logic acc_w; // A write access phase.
    logic tmr_w; // A write to the timer register.
    logic [15:0] wr_count; // Count field of the write data.
    assign pend = FIFO_COND & FIFO_COND_EN;
    assign acc_w = PSEL && PENABLE && PWRITE;
    assign tmr_w = acc_w && PADDR == OFS_TS_TIMER;
    assign wr_count = PWDATA[31:16];
    // Shadows let the timer checks know the mode without seeing inside.
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            cap_r <= 1'b0;
            pre_r <= 16'h0000;
        end else begin
            if (acc_w && PADDR == OFS_CONTROL) begin
                cap_r <= PWDATA[CAPTURE_BIT];
            end
            if (tmr_w) begin
                pre_r <= PWDATA[15:0];
            end
        end
    end
    pend_read_a: assert property (
        PSEL && PENABLE && !PWRITE && PADDR == OFS_FIFO_PEND
        |-> PRDATA == $past(pend)) else $error("pending read wrong");
    none_code_a: assert property (
        pend == 32'h0 |-> INTERRUPT_CODE == INT_CODE_NONE)
        else $error("code not none");
    low_code_a: assert property (
        pend != 32'h0 |-> INTERRUPT_CODE[6:5] == 2'h0
        && pend[INTERRUPT_CODE[4:0]]
        && (pend & ((32'h1 << INTERRUPT_CODE[4:0]) - 32'h1)) == 32'h0)
        else $error("code not lowest pending");
    timer_frozen_a: assert property (
        !cap_r && !tmr_w |=> $stable(TIMESTAMP_COUNT))
        else $error("timer moved while frozen");
    timer_step_a: assert property (
        !tmr_w |=> TIMESTAMP_COUNT == $past(TIMESTAMP_COUNT) + 16'h1
        || $stable(TIMESTAMP_COUNT)) else $error("timer jumped");
    prescale_zero_a: assert property (
        cap_r && pre_r == 16'h0 && !tmr_w
        |=> TIMESTAMP_COUNT == $past(TIMESTAMP_COUNT) + 16'h1)
        else $error("no tick with prescale zero");
    timer_load_a: assert property (
        tmr_w |=> TIMESTAMP_COUNT == $past(wr_count))
        else $error("timer write not loaded");
    rollover_flag_a: assert property (
        (!tmr_w && TIMESTAMP_COUNT == 16'hFFFF) ##1
        TIMESTAMP_COUNT == 16'h0 |-> ##[0:1] TIMER_OVERFLOW)
        else $error("rollover not flagged");
    ovf_pulse_a: assert property (
        TIMER_OVERFLOW |=> !TIMER_OVERFLOW) else $error("overflow too long");
endmodule

bind cfstm_top cfstm_asserts u_chk (
    .REF_CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .FIFO_COND, .FIFO_COND_EN, .TIMESTAMP_COUNT, .TIMER_OVERFLOW,
    .INTERRUPT_CODE
);

// ### cfstm_fifo_model.sv
// Behavioural model of the receive FIFOs that feed the status block.
module cfstm_fifo_model #(
    parameter int DEPTH = 2
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // One push and one pop strobe per FIFO.
    input wire logic [31:0] push,
    input wire logic [31:0] pop,
    // Status towards the block.
    output logic [31:0] cond,
    output logic [31:0] ovf_set
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cnt_r [32]; // Fill level per FIFO.
    // A push into a full FIFO is lost and reported as an overflow.
    always_ff @(posedge clk) begin
        for (int i = 0; i < 32; i++) begin
            ovf_set[i] <= !srst && push[i] && cnt_r[i] == DEPTH;
            if (srst) begin
                cnt_r[i] <= 2'h0;
            end else if (push[i] && cnt_r[i] < DEPTH) begin
                cnt_r[i] <= cnt_r[i] + 2'h1;
            end else if (pop[i] && cnt_r[i] != 2'h0) begin
                cnt_r[i] <= cnt_r[i] - 2'h1;
            end
        end
    end
    // A FIFO holding data raises its condition.
    always_comb begin
        for (int i = 0; i < 32; i++) begin
            cond[i] = cnt_r[i] != 2'h0;
        end
    end
endmodule

// ### cfstm_top_tb.sv
// Self-checking bench for the CAN FIFO status, timer and mask block.
module cfstm_top_tb import cfstm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [1:0] s;
        cfstm_id_s m;
        cfstm_id_s f;
        logic e;
    } cfstm_row_s;
    logic REF_CLK, SRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic TIMER_OVERFLOW, IRQ;
    logic [7:0] PADDR;
    logic [31:0] PWDATA, PRDATA, cond, en, ovf, oclr, push, pop, m3, q;
    cfstm_id_s msg;
    cfstm_id_s [3:0] fid;
    logic [3:0][1:0] sel;
    logic [3:0] hit;
    logic [15:0] ts, c0;
    logic [6:0] code;
    int failures = 0;
    int cmp_count = 0;
    int n;
    logic [7:0] offs[6] = '{OFS_FIFO_PEND, OFS_RX_OVF, OFS_TS_TIMER,
                            OFS_MASK0, OFS_MASK1, OFS_MASK2};
    // Selector, message, filter and expected hit, applied to all four filters.
    cfstm_row_s rows[7] = '{
        '{2'h0, '{11'h123, 18'h0, 1'h0}, '{11'h123, 18'h3, 1'h0}, 1'h1},
        '{2'h0, '{11'h123, 18'h0, 1'h0}, '{11'h122, 18'h0, 1'h0}, 1'h0},
        '{2'h1, '{11'h0, 18'h155, 1'h1}, '{11'h7FF, 18'h155, 1'h1}, 1'h1},
        '{2'h1, '{11'h0, 18'h154, 1'h1}, '{11'h0, 18'h155, 1'h1}, 1'h0},
        '{2'h1, '{11'h0, 18'h155, 1'h0}, '{11'h0, 18'h155, 1'h1}, 1'h0},
        '{2'h2, '{11'h1, 18'h2, 1'h0}, '{11'h3, 18'h4, 1'h1}, 1'h1},
        '{2'h3, '{11'h1, 18'h0, 1'h1}, '{11'h1, 18'h0, 1'h0}, 1'h0}};
    cfstm_top DUT (
        .REF_CLK, .SRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
        .PRDATA, .PREADY, .PSLVERR, .FIFO_COND(cond), .FIFO_COND_EN(en),
        .FIFO_OVF_SET(ovf), .FIFO_OVF_CLR(oclr), .MSG_ID(msg),
        .FILTER_ID(fid), .MASK_SELECTOR(sel), .MASK3_VALUE(m3),
        .FILTER_MATCH(hit), .TIMESTAMP_COUNT(ts), .TIMER_OVERFLOW,
        .INTERRUPT_CODE(code), .IRQ);
    cfstm_fifo_model u_fifo (.clk(REF_CLK), .srst(SRST), .push(push),
        .pop(pop), .cond(cond), .ovf_set(ovf));
    initial begin
        REF_CLK = 1'b0;
        forever #25 REF_CLK = ~REF_CLK;
    end
    // Compare and count; an unknown never passes.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One APB transfer; read data lands in q.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge REF_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        // The wait ends once PREADY is high; only the watchdog ends one that never does.
        do begin
            @(posedge REF_CLK);
        end while (PREADY !== 1'b1);
        q = PRDATA;
        chk({31'h0, PSLVERR}, 32'h0);
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge REF_CLK);
        #1;
    endtask
    task automatic fpush(input logic [31:0] u, input logic [31:0] d);
        @(posedge REF_CLK);
        push <= u;
        pop <= d;
        @(posedge REF_CLK);
        push <= 32'h0;
        pop <= 32'h0;
    endtask
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Watchdog: the sequence needs well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge REF_CLK);
        failures++;
        close_out;
    end
    initial begin
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
        {en, oclr, push, pop, msg, fid, sel} = '0;
        m3 = 32'h0008_0000;
        SRST = 1'b1;
        repeat (8) @(posedge REF_CLK);
        SRST <= 1'b0;
        foreach (offs[i]) rd(offs[i], 32'h0);
        chk({25'h0, code}, {25'h0, INT_CODE_NONE});
        wr(OFS_MASK0, 32'hFFFF_FFFF);
        rd(OFS_MASK0, 32'h0);
        wr(OFS_CONTROL, 32'h0080_0000);
        wr(OFS_MASK0, 32'hFFFF_FFFF);
        rd(OFS_MASK0, 32'hFFEB_FFFF);
        wr(OFS_MASK0, 32'hFFE0_0000);
        wr(OFS_MASK1, 32'h000B_FFFF);
        wr(OFS_MASK2, 32'h0);
        wr(8'h3C, 32'hFFFF_FFFF);
        rd(8'h3C, 32'h0);
        foreach (rows[i]) begin
            @(posedge REF_CLK);
            sel <= {4{rows[i].s}};
            msg <= rows[i].m;
            fid <= {4{rows[i].f}};
            tick(1);
            chk({28'h0, hit}, {28'h0, {4{rows[i].e}}});
        end
        // Timer rates, restart on write, freeze and rollover.
        wr(OFS_CONTROL, 32'h0090_0000);
        wr(OFS_TS_TIMER, 32'h0);
        tick(1);
        c0 = ts;
        tick(10);
        chk({16'h0, ts}, c0 + 16'hA);
        wr(OFS_TS_TIMER, 32'h0000_0003);
        tick(1);
        c0 = ts;
        tick(30);
        chk({16'h0, ts}, c0 + 16'hA);
        wr(OFS_TS_TIMER, 32'h0005_0003);
        tick(2);
        chk({16'h0, ts}, 32'h5);
        tick(2);
        chk({16'h0, ts}, 32'h6);
        wr(OFS_CONTROL, 32'h0080_0000);
        tick(1);
        c0 = ts;
        tick(20);
        chk({16'h0, ts}, {16'h0, c0});
        wr(OFS_CONTROL, 32'h0090_0000);
        wr(OFS_TS_TIMER, 32'hFFFF_0000);
        for (n = 0; n < 4 && TIMER_OVERFLOW !== 1'b1; n++) tick(1);
        chk({31'h0, TIMER_OVERFLOW}, 32'h1);
        chk({31'h0, IRQ}, 32'h0);
        wr(OFS_IRQ_MASK, 32'h1);
        tick(1);
        chk({31'h0, IRQ}, 32'h1);
        rd(OFS_IRQ_STAT, 32'h1);
        tick(1);
        chk({31'h0, IRQ}, 32'h0);
        // Pending vector, interrupt code and overflow.
        en <= 32'hFFFF_FFFF;
        fpush(32'h24, 32'h0);
        rd(OFS_FIFO_PEND, 32'h24);
        chk({25'h0, code}, 32'h2);
        en <= 32'hFFFF_FFFB;
        tick(1);
        chk({25'h0, code}, 32'h5);
        rd(OFS_INT_CODE, 32'h5);
        rd(OFS_FIFO_PEND, 32'h20);
        fpush(32'h0, 32'h20);
        rd(OFS_FIFO_PEND, 32'h0);
        chk({25'h0, code}, {25'h0, INT_CODE_NONE});
        repeat (3) fpush(32'h80, 32'h0);
        tick(2);
        rd(OFS_RX_OVF, 32'h80);
        rd(OFS_IRQ_STAT, 32'h6);
        @(posedge REF_CLK);
        oclr <= 32'h80;
        @(posedge REF_CLK);
        oclr <= 32'h0;
        rd(OFS_RX_OVF, 32'h0);
        // Reset in mid-run returns the registers to zero.
        @(posedge REF_CLK);
        SRST <= 1'b1;
        repeat (2) @(posedge REF_CLK);
        SRST <= 1'b0;
        rd(OFS_TS_TIMER, 32'h0);
        rd(OFS_MASK1, 32'h0);
        close_out;
    end
endmodule
